// >>> core/branch_and_operand_address_gen.sv
// branch target and operand address generation with an ahb-lite register slave
//
// Behaviour
// RULE1 - register-direct branch loads pc from triple register
// RULE2 - software clears triple register upper nibble
// RULE3 - pair-indirect branch reads two bytes, nibble zero
// RULE4 - triple-indirect branch reads three bytes into pc
// RULE5 - software stores zero nibble in memory target
// RULE6 - implied registers come from selected bank
// RULE7 - swap bit moves accumulator, count, second registers
// RULE8 - named accumulator operands resolved by swap bit
// RULE9 - swap bit set only for legacy code
// RULE10 - multiply uses accumulator byte or pair
// RULE11 - divide uses accumulator pair or extended concat
// RULE12 - mac accumulates concat, second/count are pointers
// RULE13 - adjust, extend, compare, rotate use accumulator byte
// RULE14 - correlation and string use count byte
// RULE15 - four-bit code selects byte registers 0..15
// RULE16 - three-bit code selects pairs 0..7
// RULE17 - triple field selects registers four to seven
// RULE18 - immediates of 8, 16, 24 bits
// RULE19 - table move address in location-dependent page
// RULE20 - direct address nibble follows location setting
// RULE21 - 16-bit direct address reaches base area
// RULE22 - base-area branch keeps pc nibble zero
// RULE23 - calls push return address, jumps do not
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.
module branch_and_operand_address_gen (
   // ahb-lite slave
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // program/data memory read port
   output agen_pkg::mem_req_s mem_req,
   input wire agen_pkg::mem_rsp_s mem_rsp,
   // system stack and program counter
   output agen_pkg::stack_s stack_out,
   output agen_pkg::branch_s branch_out
);
   import agen_pkg::*;

   typedef logic [BYTES_PER_BANK-1:0][7:0] bank_t;

   typedef struct packed {
      logic [2:0] bank;
      logic swap;
      logic loc;
      op_e op;
      logic [3:0] code;
      cls_e cls;
      iw_e iw;
      logic [23:0] imm;
      logic [19:0] next_pc;
      logic [7:0] reg_idx;
      logic [NUM_BANKS-1:0][BYTES_PER_BANK-1:0][7:0] regs;
      logic go;
      logic busy;
      logic done;
      st_e fsm;
      logic [1:0] cnt;
      logic [1:0] need;
      logic [1:0] fetch_seen;
      logic [23:0] ptr;
      logic [23:0] gather;
      logic [19:0] target;
      logic [23:0] opaddr;
      sel_s sel;
      mem_req_s mem;
      stack_s stk;
      branch_s br;
      logic dp_we;
      logic dp_re;
      logic [7:0] dp_addr;
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
   } st_s;

   st_s s_q;
   st_s s_d;

   // ----------------------------------------------------------------
   // register decode helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] pair_of(input bank_t b, input logic [2:0] p);
      pair_of = {b[{p, 1'b1}], b[{p, 1'b0}]};
   endfunction

   // triple register n (4..7) is pair n with its extension byte on top
   function automatic logic [23:0] triple_of(input bank_t b, input logic [1:0] t);
      logic [4:0] ext;
      ext = EXT_BASE + {3'h0, t};
      triple_of = {b[ext], pair_of(b, {1'b1, t})}; // RULE17
   endfunction

   // legacy swap moves byte names up by four and the accumulator pair up by two
   function automatic logic [3:0] named_byte(input logic [3:0] idx, input logic swap);
      named_byte = swap ? idx + SWAP_BYTE_STEP : idx; // RULE7
   endfunction

   function automatic logic [2:0] acc_pair(input logic swap);
      acc_pair = swap ? PAIR_ACC + SWAP_PAIR_STEP : PAIR_ACC; // RULE7
   endfunction

   // slot within a bank addressed by the software index register
   function automatic logic [4:0] reg_slot(input logic [7:0] idx);
      reg_slot = idx[4] ? EXT_BASE + {3'h0, idx[1:0]} : {1'b0, idx[3:0]};
   endfunction

   // implied operands of an instruction class, all in the current bank
   function automatic sel_s implied_sel(input cls_e c, input logic [2:0] bk, input logic sw);
      sel_s r;
      logic [6:0] acc;
      logic [5:0] accp;
      logic [5:0] third;
      r = '0;
      acc = {bk, named_byte(IDX_ACC, sw)}; // RULE6
      accp = {bk, acc_pair(sw)};
      third = {bk, PAIR_THIRD};
      case (c)
         CL_MUL_BYTE:
         begin
            r.byte_a = acc; // RULE10
            r.pair_a = accp;
         end
         CL_MUL_WORD, CL_DIV_WORD: r.pair_a = accp; // RULE10 RULE11
         CL_DIV_EXT:
         begin
            r.pair_a = accp; // RULE11
            r.pair_b = third;
         end
         CL_MAC:
         begin
            r.pair_a = accp; // RULE12
            r.pair_b = third;
            r.byte_a = {bk, named_byte(IDX_SECOND, sw)};
            r.byte_b = {bk, named_byte(IDX_COUNT, sw)};
         end
         CL_DEC_ADJ, CL_PIN_CMP: r.byte_a = acc; // RULE13
         CL_EXTEND:
         begin
            r.byte_a = acc; // RULE13
            r.pair_a = accp;
         end
         CL_DIGIT_ROT:
         begin
            r.byte_a = acc; // RULE13
            r.low_nibble = 1'b1;
         end
         CL_COUNTED: r.byte_a = {bk, named_byte(IDX_COUNT, sw)}; // RULE14
         default: r = '0;
      endcase
      implied_sel = r;
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   // one combinational pass: sequencer first, then the bus data phase
   always_comb
   begin
      bank_t bk;
      logic [23:0] g;
      logic [1:0] nxt;
      logic [31:0] rdata;
      s_d = s_q;
      bk = s_q.regs[s_q.bank];
      g = s_q.gather;
      nxt = 2'(s_q.cnt + 2'h1);
      rdata = 32'h0;
      s_d.mem.rd = 1'b0;
      s_d.stk.push = 1'b0;
      s_d.br.load = 1'b0;
      case (s_q.fsm)
         ST_IDLE:
         begin
            if (s_q.go)
            begin
               s_d.go = 1'b0;
               s_d.busy = 1'b0;
               s_d.done = 1'b1;
               s_d.cnt = 2'h0;
               s_d.gather = 24'h0;
               s_d.fetch_seen = 2'h0;
               case (s_q.op)
                  OP_BR_RG, OP_CALL_RG:
                  begin
                     // only 20 bits reach the pc; software keeps the top nibble clear
                     s_d.target = 20'(triple_of(bk, s_q.code[1:0])); // RULE1 RULE2
                     s_d.fsm = (s_q.op == OP_CALL_RG) ? ST_PUSH : ST_LOAD; // RULE23
                     s_d.busy = 1'b1;
                     s_d.done = 1'b0;
                  end
                  OP_BR_IRP, OP_CALL_IRP:
                  begin
                     s_d.ptr = {8'h00, pair_of(bk, s_q.code[2:0])}; // RULE3
                     s_d.need = RP_IND_BYTES;
                     s_d.fsm = ST_FETCH;
                     s_d.busy = 1'b1;
                     s_d.done = 1'b0;
                  end
                  OP_BR_IRG, OP_CALL_IRG:
                  begin
                     s_d.ptr = triple_of(bk, s_q.code[1:0]); // RULE4
                     s_d.need = RG_IND_BYTES;
                     s_d.fsm = ST_FETCH;
                     s_d.busy = 1'b1;
                     s_d.done = 1'b0;
                  end
                  OP_IMPLIED: s_d.sel = implied_sel(s_q.cls, s_q.bank, s_q.swap); // RULE6
                  OP_NAMED:
                  begin
                     // swap bit is read now, at execution, not when the command was set
                     s_d.sel = '0;
                     case (name_e'(s_q.code[2:0]))
                        NM_ACC: s_d.sel.byte_a = {s_q.bank, named_byte(IDX_ACC, s_q.swap)}; // RULE8
                        NM_LOW: s_d.sel.byte_a = {s_q.bank, named_byte(IDX_LOW, s_q.swap)}; // RULE8
                        NM_SECOND: s_d.sel.byte_a = {s_q.bank, named_byte(IDX_SECOND, s_q.swap)};
                        NM_COUNT: s_d.sel.byte_a = {s_q.bank, named_byte(IDX_COUNT, s_q.swap)};
                        NM_ACC_PAIR: s_d.sel.pair_a = {s_q.bank, acc_pair(s_q.swap)}; // RULE8
                        default: s_d.sel = '0;
                     endcase
                  end
                  OP_REG_BYTE:
                  begin
                     s_d.sel = '0;
                     s_d.sel.byte_a = {s_q.bank, s_q.code}; // RULE15
                     s_d.opaddr = {16'h0, bk[s_q.code]};
                  end
                  OP_REG_PAIR:
                  begin
                     s_d.sel = '0;
                     s_d.sel.pair_a = {s_q.bank, s_q.code[2:0]}; // RULE16
                     s_d.opaddr = {8'h0, pair_of(bk, s_q.code[2:0])};
                  end
                  OP_REG_TRIPLE:
                  begin
                     s_d.sel = '0;
                     s_d.sel.pair_a = {s_q.bank, 1'b1, s_q.code[1:0]}; // RULE17
                     s_d.opaddr = triple_of(bk, s_q.code[1:0]);
                  end
                  OP_IMM:
                  begin
                     case (s_q.iw)
                        IW_8: s_d.opaddr = {16'h0, s_q.imm[7:0]}; // RULE18
                        IW_16: s_d.opaddr = {8'h0, s_q.imm[15:0]}; // RULE18
                        default: s_d.opaddr = s_q.imm; // RULE18
                     endcase
                  end
                  OP_DIR8:
                  begin
                     s_d.opaddr = {4'h0, (s_q.loc ? PAGE_LOCF : PAGE_LOC0) | {12'h0, s_q.imm[7:0]}}; // RULE19 RULE20
                  end
                  OP_DIR16: s_d.opaddr = {8'h00, s_q.imm[15:0]}; // RULE21
                  default: s_d.done = 1'b1;
               endcase
            end
         end
         ST_FETCH:
         begin
            // consecutive bytes, lowest address first
            s_d.mem.rd = 1'b1;
            s_d.mem.addr = 24'(s_q.ptr + {22'h0, s_q.cnt});
            s_d.fetch_seen = 2'(s_q.fetch_seen + 2'h1);
            s_d.fsm = ST_WAIT;
         end
         ST_WAIT:
         begin
            if (mem_rsp.valid)
            begin
               g[{s_q.cnt, 3'b000} +: 8] = mem_rsp.data;
               s_d.gather = g;
               s_d.cnt = nxt;
               if (nxt == s_q.need)
               begin
                  // pair form is confined to the base area; the triple form trusts memory
                  s_d.target = (s_q.need == RP_IND_BYTES) ? {BASE_NIBBLE, g[15:0]} : g[19:0]; // RULE3 RULE22 RULE4 RULE5
                  s_d.fsm = (s_q.op == OP_CALL_IRP || s_q.op == OP_CALL_IRG) ? ST_PUSH : ST_LOAD; // RULE23
               end
               else
               begin
                  s_d.fsm = ST_FETCH;
               end
            end
         end
         ST_PUSH:
         begin
            s_d.stk.push = 1'b1; // RULE23
            s_d.stk.data = s_q.next_pc;
            s_d.fsm = ST_LOAD;
         end
         ST_LOAD:
         begin
            s_d.br.load = 1'b1; // RULE1 RULE3 RULE4
            s_d.br.value = s_q.target;
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
            s_d.fsm = ST_IDLE;
         end
         default: s_d.fsm = ST_IDLE;
      endcase

      // bus data phase: writes land at once, reads come one wait state later
      s_d.dp_we = 1'b0;
      if (s_q.dp_we)
      begin
         case (s_q.dp_addr)
            OFF_CTRL:
            begin
               s_d.bank = hwdata[CTRL_BANK_LSB +: 3];
               s_d.swap = hwdata[CTRL_SWAP];
               s_d.loc = hwdata[CTRL_LOC];
            end
            OFF_CMD:
            begin
               // a command while busy is dropped so the running one is not corrupted
               if (!s_q.busy)
               begin
                  s_d.op = op_e'(hwdata[CMD_OP_LSB +: 4]);
                  s_d.code = hwdata[CMD_CODE_LSB +: 4];
                  s_d.cls = cls_e'(hwdata[CMD_CLS_LSB +: 4]);
                  s_d.iw = iw_e'(hwdata[CMD_IW_LSB +: 2]);
                  s_d.go = 1'b1;
                  s_d.busy = 1'b1;
                  s_d.done = 1'b0;
               end
            end
            OFF_IMM: s_d.imm = hwdata[23:0];
            OFF_NEXTPC: s_d.next_pc = hwdata[19:0];
            OFF_REGIDX: s_d.reg_idx = hwdata[7:0];
            OFF_REGDATA: s_d.regs[s_q.reg_idx[7:5]][reg_slot(s_q.reg_idx)] = hwdata[7:0];
            default: s_d.dp_we = 1'b0;
         endcase
      end
      if (s_q.dp_re)
      begin
         case (s_q.dp_addr)
            OFF_CTRL: rdata = {27'h0, s_q.loc, s_q.swap, s_q.bank};
            OFF_CMD: rdata = {18'h0, s_q.iw, s_q.cls, s_q.code, s_q.op};
            OFF_IMM: rdata = {8'h0, s_q.imm};
            OFF_NEXTPC: rdata = {12'h0, s_q.next_pc};
            OFF_REGIDX: rdata = {24'h0, s_q.reg_idx};
            OFF_REGDATA: rdata = {24'h0, s_q.regs[s_q.reg_idx[7:5]][reg_slot(s_q.reg_idx)]};
            OFF_STATUS: rdata = {30'h0, s_q.done, s_q.busy};
            OFF_PC: rdata = {12'h0, s_q.br.value};
            OFF_OPADDR: rdata = {8'h0, s_q.opaddr};
            OFF_SEL: rdata = {5'h0, s_q.sel};
            default: rdata = 32'h0;
         endcase
         s_d.hrdata = rdata;
         s_d.hreadyout = 1'b1;
         s_d.dp_re = 1'b0;
      end
      // address phase: only whole-word single transfers are expected
      if (hsel && htrans[1] && hready)
      begin
         s_d.dp_addr = haddr[7:0];
         s_d.dp_we = hwrite;
         s_d.dp_re = !hwrite;
         s_d.hreadyout = hwrite;
      end
      s_d.hresp = HRESP_OKAY;
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s_q <= '0;
         s_q.hreadyout <= RST_HREADY;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign hreadyout = s_q.hreadyout;
   assign hresp = s_q.hresp;
   assign hrdata = s_q.hrdata;
   assign mem_req = s_q.mem;
   assign stack_out = s_q.stk;
   assign branch_out = s_q.br;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic start_now;
   logic [19:0] rg_target_now;
   assign start_now = (s_q.fsm == ST_IDLE) && s_q.go;
   assign rg_target_now = 20'(triple_of(s_q.regs[s_q.bank], s_q.code[1:0]));

   a_rg_direct_load: assert property (@(posedge hclk) disable iff (!hresetn) // RULE1
      (start_now && s_q.op == OP_BR_RG) |-> ##2
      (s_q.br.load && s_q.br.value == $past(rg_target_now, 2)))
      else $error("register-direct jump loaded the wrong target");
   a_jump_no_push: assert property (@(posedge hclk) disable iff (!hresetn) // RULE23
      (start_now && s_q.op == OP_BR_RG) |=> !s_q.stk.push ##1 (!s_q.stk.push && s_q.br.load))
      else $error("jump pushed the stack or failed to load");
   a_call_push_first: assert property (@(posedge hclk) disable iff (!hresetn) // RULE23
      (start_now && s_q.op == OP_CALL_RG) |-> ##2
      (s_q.stk.push && !s_q.br.load && s_q.stk.data == $past(s_q.next_pc, 2)) ##1 s_q.br.load)
      else $error("call did not push return address before loading");
   a_pair_ind_bytes: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
      (s_q.br.load && (s_q.op == OP_BR_IRP || s_q.op == OP_CALL_IRP)) |->
      (s_q.fetch_seen == RP_IND_BYTES && s_q.br.value[19:16] == BASE_NIBBLE))
      else $error("pair-indirect branch read wrong byte count or nibble");
   a_triple_ind_bytes: assert property (@(posedge hclk) disable iff (!hresetn) // RULE4
      (s_q.br.load && (s_q.op == OP_BR_IRG || s_q.op == OP_CALL_IRG)) |->
      (s_q.fetch_seen == RG_IND_BYTES && s_q.br.value == s_q.gather[19:0]))
      else $error("triple-indirect branch read wrong byte count");
   a_swap_acc_map: assert property (@(posedge hclk) disable iff (!hresetn) // RULE7
      (start_now && s_q.op == OP_IMPLIED && s_q.cls == CL_DEC_ADJ) |=>
      (s_q.sel.byte_a == {$past(s_q.bank), ($past(s_q.swap) ? 4'h5 : 4'h1)}))
      else $error("accumulator byte not mapped through swap bit and bank");
   a_count_map: assert property (@(posedge hclk) disable iff (!hresetn) // RULE14
      (start_now && s_q.op == OP_IMPLIED && s_q.cls == CL_COUNTED) |=>
      (s_q.sel.byte_a[3:0] == ($past(s_q.swap) ? 4'h6 : 4'h2)))
      else $error("count byte mapped wrongly");
   a_dir8_page: assert property (@(posedge hclk) disable iff (!hresetn) // RULE19
      (start_now && s_q.op == OP_DIR8) |=>
      (s_q.opaddr[19:8] == ($past(s_q.loc) ? 12'hffe : 12'h0fe) &&
      s_q.opaddr[7:0] == $past(s_q.imm[7:0]) && s_q.opaddr[23:20] == 4'h0))
      else $error("table-move address outside its page");
   a_dir16_base: assert property (@(posedge hclk) disable iff (!hresetn) // RULE21
      (start_now && s_q.op == OP_DIR16) |=> (s_q.opaddr == {8'h00, $past(s_q.imm[15:0])}))
      else $error("16-bit direct address left the base area");
   a_imm8_width: assert property (@(posedge hclk) disable iff (!hresetn) // RULE18
      (start_now && s_q.op == OP_IMM && s_q.iw == IW_8) |=> (s_q.opaddr[23:8] == 16'h0))
      else $error("8-bit immediate carried upper bits");
   a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
      (hsel && htrans[1] && hready && !hwrite) |=> !hreadyout ##1 hreadyout)
      else $error("read did not take exactly one wait state");
endmodule

// >>> inc/agen_pkg.sv
// shared constants, types and carriers for the branch and operand address generator
package agen_pkg;
   // register offsets on the ahb-lite slave (byte addresses)
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CMD = 8'h04;
   localparam logic [7:0] OFF_IMM = 8'h08;
   localparam logic [7:0] OFF_NEXTPC = 8'h0c;
   localparam logic [7:0] OFF_REGIDX = 8'h10;
   localparam logic [7:0] OFF_REGDATA = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   localparam logic [7:0] OFF_PC = 8'h1c;
   localparam logic [7:0] OFF_OPADDR = 8'h20;
   localparam logic [7:0] OFF_SEL = 8'h24;
   // field positions
   localparam int CTRL_BANK_LSB = 0;
   localparam int CTRL_SWAP = 3;
   localparam int CTRL_LOC = 4;
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_CODE_LSB = 4;
   localparam int CMD_CLS_LSB = 8;
   localparam int CMD_IW_LSB = 12;
   // register bank layout
   localparam int NUM_BANKS = 8;
   localparam int BYTES_PER_BANK = 20;
   localparam logic [4:0] EXT_BASE = 5'h10;
   localparam logic [3:0] IDX_LOW = 4'h0;
   localparam logic [3:0] IDX_ACC = 4'h1;
   localparam logic [3:0] IDX_COUNT = 4'h2;
   localparam logic [3:0] IDX_SECOND = 4'h3;
   localparam logic [3:0] SWAP_BYTE_STEP = 4'h4;
   localparam logic [2:0] PAIR_ACC = 3'h0;
   localparam logic [2:0] PAIR_THIRD = 3'h6;
   localparam logic [2:0] SWAP_PAIR_STEP = 3'h2;
   // addressing constants
   localparam logic [19:0] PAGE_LOC0 = 20'h0fe00;
   localparam logic [19:0] PAGE_LOCF = 20'hffe00;
   localparam logic [3:0] BASE_NIBBLE = 4'h0;
   localparam logic [1:0] RP_IND_BYTES = 2'h2;
   localparam logic [1:0] RG_IND_BYTES = 2'h3;
   // reset values
   localparam logic RST_HREADY = 1'b1;
   localparam logic HRESP_OKAY = 1'b0;

   typedef enum logic [3:0] {
      OP_NOP = 4'h0, OP_BR_RG = 4'h1, OP_CALL_RG = 4'h2, OP_BR_IRP = 4'h3,
      OP_CALL_IRP = 4'h4, OP_BR_IRG = 4'h5, OP_CALL_IRG = 4'h6, OP_IMPLIED = 4'h7,
      OP_NAMED = 4'h8, OP_REG_BYTE = 4'h9, OP_REG_PAIR = 4'ha, OP_REG_TRIPLE = 4'hb,
      OP_IMM = 4'hc, OP_DIR8 = 4'hd, OP_DIR16 = 4'he
   } op_e;
   typedef enum logic [3:0] {
      CL_MUL_BYTE = 4'h0, CL_MUL_WORD = 4'h1, CL_DIV_WORD = 4'h2, CL_DIV_EXT = 4'h3,
      CL_MAC = 4'h4, CL_DEC_ADJ = 4'h5, CL_EXTEND = 4'h6, CL_PIN_CMP = 4'h7,
      CL_DIGIT_ROT = 4'h8, CL_COUNTED = 4'h9
   } cls_e;
   typedef enum logic [2:0] {
      NM_ACC = 3'h0, NM_LOW = 3'h1, NM_SECOND = 3'h2, NM_COUNT = 3'h3, NM_ACC_PAIR = 3'h4
   } name_e;
   typedef enum logic [1:0] {IW_8 = 2'h0, IW_16 = 2'h1, IW_24 = 2'h2} iw_e;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0, ST_FETCH = 3'h1, ST_WAIT = 3'h2, ST_PUSH = 3'h3, ST_LOAD = 3'h4
   } st_e;

   typedef struct packed {
      logic rd;
      logic [23:0] addr;
   } mem_req_s;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } mem_rsp_s;
   typedef struct packed {
      logic push;
      logic [19:0] data;
   } stack_s;
   typedef struct packed {
      logic load;
      logic [19:0] value;
   } branch_s;
   // resolved register selection: {bank,byte} and {bank,pair}
   typedef struct packed {
      logic low_nibble;
      logic [5:0] pair_b;
      logic [5:0] pair_a;
      logic [6:0] byte_b;
      logic [6:0] byte_a;
   } sel_s;
endpackage

// >>> verif/agen_mem_model.sv
// behavioural program/data memory answering byte reads from the address generator
module agen_mem_model (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // latency choice: 0 answers next cycle, 1 answers four cycles after the read
   input wire logic slow,
   // byte read port
   input wire agen_pkg::mem_req_s mem_req,
   output agen_pkg::mem_rsp_s mem_rsp
);
   timeunit 1ns;
   timeprecision 1ps;
   import agen_pkg::*;
   logic [7:0] mem [256];
   logic [7:0] a_q;
   logic [7:0] last_q;
   logic [1:0] cnt_q;
   // one answer per read; an idle data bus shows the inverse of the last byte
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mem_rsp <= '0;
         a_q <= 8'h00;
         last_q <= 8'h00;
         cnt_q <= 2'h0;
      end
      else
      begin
         mem_rsp <= {1'b0, ~last_q};
         if (mem_req.rd && !slow)
         begin
            mem_rsp <= {1'b1, mem[mem_req.addr[7:0]]};
            last_q <= mem[mem_req.addr[7:0]];
         end
         else if (mem_req.rd)
         begin
            a_q <= mem_req.addr[7:0];
            cnt_q <= 2'h3;
         end
         else if (cnt_q == 2'h1)
         begin
            mem_rsp <= {1'b1, mem[a_q]};
            last_q <= mem[a_q];
         end
         if (!mem_req.rd && cnt_q != 2'h0)
            cnt_q <= cnt_q - 2'h1;
      end
   end
endmodule

// >>> verif/branch_and_operand_address_gen_bench.sv
// self-checking bench for the branch and operand address generator
module branch_and_operand_address_gen_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import agen_pkg::*;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rv;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp;
   logic [23:0] last_a;
   mem_req_s mem_req;
   mem_rsp_s mem_rsp;
   stack_s stack_out;
   branch_s branch_out;
   int n_mismatch = 0, cmp_count = 0, n_load = 0, n_push = 0, n_rd = 0;
   always #2.5 hclk = ~hclk;
   branch_and_operand_address_gen i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .mem_req(mem_req), .mem_rsp(mem_rsp), .stack_out(stack_out), .branch_out(branch_out));
   agen_mem_model i_mem (.hclk(hclk), .hresetn(hresetn), .slow(slow), .mem_req(mem_req),
      .mem_rsp(mem_rsp));
   // count pulses; values stand afterwards so they are judged once a command ends
   always @(posedge hclk)
   begin
      if (branch_out.load === 1'b1) n_load++;
      if (stack_out.push === 1'b1) n_push++;
      if (mem_req.rd === 1'b1) last_a = mem_req.addr;
      if (mem_req.rd === 1'b1) n_rd++;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // single ahb-lite word transfer; the master waits as long as hready stays low
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rv = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   // commands may not overlap, so poll busy before returning
   task automatic cmd(input logic [31:0] c);
      xfer(1'b1, OFF_CMD, c);
      rv = 32'h1;
      while (rv[0] !== 1'b0) xfer(1'b0, OFF_STATUS, 32'h0);
   endtask
   task automatic setb(input logic [7:0] idx, input logic [7:0] d);
      xfer(1'b1, OFF_REGIDX, {24'h0, idx});
      xfer(1'b1, OFF_REGDATA, {24'h0, d});
   endtask
   task automatic t_direct();
      setb(8'h0e, 8'h34);
      setb(8'h0f, 8'h12);
      setb(8'h13, 8'h05);
      xfer(1'b1, OFF_NEXTPC, 32'h11111);
      cmd({24'h0, 4'h3, OP_BR_RG});
      chk("jump pc", 32'h51234, {12'h0, branch_out.value});
      chk("jump push", 32'h0, n_push);
      cmd({24'h0, 4'h3, OP_CALL_RG});
      chk("ret addr", 32'h11111, {12'h0, stack_out.data});
      chk("loads", 32'h2, n_load);
   endtask
   task automatic t_ind_pair();
      setb(8'h06, 8'h40);
      setb(8'h07, 8'h00);
      i_mem.mem[8'h40] = 8'hcd;
      i_mem.mem[8'h41] = 8'hab;
      i_mem.mem[8'h42] = 8'hff;
      slow <= 1'b1;
      n_rd = 0;
      cmd({24'h0, 4'h3, OP_CALL_IRP});
      chk("pair reads", 32'h2, n_rd);
      chk("pair last", 32'h41, {8'h0, last_a});
      xfer(1'b0, OFF_PC, 32'h0);
      chk("pair pc", 32'h0abcd, rv);
      chk("pair push", 32'h2, n_push);
   endtask
   task automatic t_ind_triple();
      setb(8'h0a, 8'h80);
      setb(8'h0b, 8'h00);
      setb(8'h11, 8'h00);
      i_mem.mem[8'h80] = 8'h78;
      i_mem.mem[8'h81] = 8'h56;
      i_mem.mem[8'h82] = 8'h03;
      slow <= 1'b0;
      n_rd = 0;
      cmd({24'h0, 4'h1, OP_BR_IRG});
      chk("trip reads", 32'h3, n_rd);
      chk("trip last", 32'h82, {8'h0, last_a});
      chk("trip pc", 32'h35678, {12'h0, branch_out.value});
      chk("trip push", 32'h2, n_push);
   endtask
   // accumulator, low, second and count move by four registers when swapped
   task automatic t_named();
      logic [3:0] nm_idx [4] = '{4'h1, 4'h0, 4'h3, 4'h2};
      for (int s = 0; s < 2; s++)
      begin
         xfer(1'b1, OFF_CTRL, {28'h0, s[0], 3'h5});
         for (int n = 0; n < 4; n++)
         begin
            cmd({24'h0, 1'b0, n[2:0], OP_NAMED});
            xfer(1'b0, OFF_SEL, 32'h0);
            chk("byte sel", {25'h0, 3'h5, nm_idx[n] + 4'(4 * s)}, {25'h0, rv[6:0]});
         end
         cmd({24'h0, 4'h4, OP_NAMED});
         xfer(1'b0, OFF_SEL, 32'h0);
         chk("pair sel", {26'h0, 3'h5, 1'b0, s[0], 1'b0}, {26'h0, rv[19:14]});
      end
   endtask
   // bank 2 with swap set
   task automatic t_implied();
      logic [31:0] c [6] = '{32'h507, 32'h307, 32'h907, 32'hd9, 32'h5a, 32'h2b};
      logic [31:0] e [6] = '{32'h25, 32'h1648000, 32'h26, 32'h2d, 32'h54000, 32'h58000};
      xfer(1'b1, OFF_CTRL, 32'ha);
      for (int i = 0; i < 6; i++)
      begin
         cmd(c[i]);
         xfer(1'b0, OFF_SEL, 32'h0);
         chk("sel", e[i], rv);
      end
   endtask
   task automatic t_addr();
      logic [31:0] imm_exp [3] = '{32'hef, 32'hcdef, 32'habcdef};
      for (int l = 0; l < 2; l++)
      begin
         xfer(1'b1, OFF_CTRL, {27'h0, l[0], 4'h0});
         xfer(1'b1, OFF_IMM, 32'h24);
         cmd({28'h0, OP_DIR8});
         xfer(1'b0, OFF_OPADDR, 32'h0);
         chk("dir8", l ? 32'hffe24 : 32'h0fe24, rv);
      end
      xfer(1'b1, OFF_IMM, 32'habcdef);
      cmd({28'h0, OP_DIR16});
      xfer(1'b0, OFF_OPADDR, 32'h0);
      chk("dir16", 32'hcdef, rv);
      for (int w = 0; w < 3; w++)
      begin
         cmd({18'h0, w[1:0], 8'h0, OP_IMM});
         xfer(1'b0, OFF_OPADDR, 32'h0);
         chk("imm", imm_exp[w], rv);
      end
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_direct();
      t_ind_pair();
      t_ind_triple();
      t_named();
      t_implied();
      t_addr();
      conclude();
   end
   // a hang stops here; the whole run needs far fewer cycles
   initial
   begin
      #50000;
      n_mismatch++;
      conclude();
   end
endmodule
